// file: cad_cfg.svh
`ifndef CAD_CFG_SVH
`define CAD_CFG_SVH

// prebyte codes
`define CAD_PRE_TO_Y      8'h90
`define CAD_PRE_IND_Y     8'h91
`define CAD_PRE_INDIRECT  8'h92

// inherent opcodes with side effects on the core
`define CAD_OP_TRAP       8'h83
`define CAD_OP_WAIT       8'h8F
`define CAD_OP_HALT       8'h8E

// address limits of the short forms
`define CAD_PAGE0_MAX     16'h00FF
`define CAD_IDX_SHORT_MAX 16'h01FE

// program counter after reset
`define CAD_RESET_PC      16'h0000

`endif

// file: cad_decoder.sv
`timescale 1ns/100ps
`include "cad_cfg.svh"

// Notes on behaviour
// (RQ1) inherent instructions are a single opcode byte with no operand bytes
// (RQ2) immediate fetches opcode then one byte used as the operand value
// (RQ3) short direct reads one address byte, operand in 00 to FF
// (RQ4) long direct reads a 16-bit address from the two following bytes
// (RQ5) indexed address is unsigned sum of X or Y and the offset
// (RQ6) indexed without offset takes no byte, uses index alone, 00 to FF
// (RQ7) short indexed reads one offset byte, addresses 00 up to 1FE
// (RQ8) long indexed reads a 16-bit offset, reaching the whole space
// (RQ9) short indirect reads pointer address, fetches byte pointer as address
// (RQ10) long indirect forms fetch a 16-bit pointer from a one-byte address
// (RQ11) indirect-indexed address is index plus the fetched pointer, unsigned
// (RQ12) short indirect-indexed uses page-zero byte pointer, addresses up to 1FE
// (RQ13) load, compare and arithmetic groups take short and long memory forms
// (RQ14) read-modify-write groups take only short memory forms
// (RQ15) relative mode adds a signed 8-bit offset to the program counter
// (RQ16) relative direct offset follows opcode; indirect gives its address
// (RQ17) instructions are one to four bytes long including the prebyte
// (RQ18) a prebyte precedes the opcode and changes its interpretation
// (RQ19) prebyte 90 moves X-based imm, direct, indexed, inherent to Y
// (RQ20) prebyte 92 turns direct forms and X-indexed into indirect forms
// (RQ21) prebyte 91 turns X indirect-indexed into Y indirect-indexed
// (RQ22) inherent set holds software trap, wait for interrupt and halt
// (RQ23) relative offset is added to the address after the jump
// (RQ24) index registers are 8-bit unsigned in every address sum
module cad_decoder #(
  parameter logic [15:0] RESET_PC = `CAD_RESET_PC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // program and data memory
  output logic                   mem_rd,
  output logic [15:0]            mem_addr,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic              mem_rvalid,
  // core execute side
  input  wire logic [7:0]        x_val,
  input  wire logic [7:0]        y_val,
  input  wire logic              dec_ack,
  input  wire logic              branch_take,
  output logic                   dec_valid,
  output cad_pkg::cad_dec_t      dec,
  output logic [15:0]            pc
);

  //--------------------------------------------------
  // decode functions
  //--------------------------------------------------
  // mode from prebyte and opcode; rows chosen by the high nibble
  function automatic cad_pkg::cad_mode_t mode_f(input logic [7:0] op,
                                               input cad_pkg::cad_pfx_t p);
    logic ind;
    ind = (p == cad_pkg::PFX_INDIRECT) || (p == cad_pkg::PFX_IND_Y);
    mode_f = cad_pkg::M_INH; // RQ1
    unique case (op[7:4])
      4'h0: mode_f = ind ? cad_pkg::M_BITREL_I : cad_pkg::M_BITREL_D; // RQ20
      4'h1: mode_f = ind ? cad_pkg::M_BIT_I : cad_pkg::M_BIT_D; // RQ20
      4'h2: mode_f = ind ? cad_pkg::M_REL_I : cad_pkg::M_REL_D; // RQ16
      4'h3, 4'hB: mode_f = ind ? cad_pkg::M_IND_S : cad_pkg::M_DIR_S; // RQ14
      4'h6, 4'hE: mode_f = ind ? cad_pkg::M_INDIDX_S : cad_pkg::M_IDX_S; // RQ21
      4'h7, 4'hF: mode_f = cad_pkg::M_IDX0;
      4'hA: mode_f = cad_pkg::M_IMM;
      4'hC: mode_f = ind ? cad_pkg::M_IND_L : cad_pkg::M_DIR_L; // RQ13
      4'hD: mode_f = ind ? cad_pkg::M_INDIDX_L : cad_pkg::M_IDX_L; // RQ13
      4'h4, 4'h5, 4'h8, 4'h9: mode_f = cad_pkg::M_INH;
    endcase
  endfunction

  // bytes that follow the opcode in the stream
  function automatic logic [1:0] opnd_n(input cad_pkg::cad_mode_t m);
    unique case (m)
      cad_pkg::M_INH, cad_pkg::M_IDX0: opnd_n = 2'd0; // RQ6
      cad_pkg::M_DIR_L, cad_pkg::M_IDX_L,
      cad_pkg::M_BITREL_D, cad_pkg::M_BITREL_I: opnd_n = 2'd2; // RQ4 RQ8
      default: opnd_n = 2'd1; // RQ2 RQ3 RQ7 RQ10
    endcase
  endfunction

  // pointer bytes fetched from page zero
  function automatic logic [1:0] ptr_n(input cad_pkg::cad_mode_t m);
    unique case (m)
      cad_pkg::M_IND_L, cad_pkg::M_INDIDX_L: ptr_n = 2'd2; // RQ10
      cad_pkg::M_IND_S, cad_pkg::M_INDIDX_S, cad_pkg::M_REL_I,
      cad_pkg::M_BIT_I, cad_pkg::M_BITREL_I: ptr_n = 2'd1; // RQ9
      default: ptr_n = 2'd0;
    endcase
  endfunction

  function automatic cad_pkg::cad_pfx_t pfx_f(input logic [7:0] b);
    unique case (b)
      `CAD_PRE_TO_Y:     pfx_f = cad_pkg::PFX_TO_Y;
      `CAD_PRE_IND_Y:    pfx_f = cad_pkg::PFX_IND_Y;
      `CAD_PRE_INDIRECT: pfx_f = cad_pkg::PFX_INDIRECT;
      default:           pfx_f = cad_pkg::PFX_NONE;
    endcase
  endfunction

  //--------------------------------------------------
  // state
  //--------------------------------------------------
  cad_pkg::cad_state_t state_ff;
  cad_pkg::cad_pfx_t   prefix_ff;
  cad_pkg::cad_mode_t  mode_ff;
  logic [7:0]          opcode_ff;
  logic [7:0]          b1_ff;
  logic [7:0]          b2_ff;
  logic [7:0]          p1_ff;
  logic [7:0]          p2_ff;
  logic [1:0]          cnt_ff;
  logic                pend_ff;
  logic                mem_rd_ff;
  logic [15:0]         mem_addr_ff;
  logic [15:0]         pc_ff;
  logic                dec_valid_ff;
  cad_pkg::cad_dec_t   dec_ff;

  logic                got;
  logic                fetching;
  logic [15:0]         nxt_addr;
  cad_pkg::cad_mode_t  nxt_mode;
  logic [7:0]          idx;
  logic [15:0]         nxt_ea;
  logic [7:0]          rel_off;
  logic                nxt_illegal;

  assign got      = pend_ff && mem_rvalid;
  assign fetching = (state_ff == cad_pkg::ST_FETCH) || (state_ff == cad_pkg::ST_OPND)
                    || (state_ff == cad_pkg::ST_PTR);
  assign nxt_mode = mode_f(mem_rdata, prefix_ff);
  // index as the calc cycle sees it, so a check one cycle later can use $past
  assign idx      = (prefix_ff == cad_pkg::PFX_TO_Y || prefix_ff == cad_pkg::PFX_IND_Y)
                    ? y_val : x_val;

  // pointer bytes wrap inside page zero so a pointer never leaves it
  always_comb
  begin
    if (state_ff == cad_pkg::ST_PTR)
      nxt_addr = {8'h00, b1_ff + {6'h00, cnt_ff}}; // RQ9 RQ10
    else
      nxt_addr = pc_ff;
  end

  //--------------------------------------------------
  // memory read requests
  //--------------------------------------------------
  // one outstanding read; a new one is issued only after the answer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mem_rd_ff   <= 1'b0;
      mem_addr_ff <= 16'h0000;
      pend_ff     <= 1'b0;
    end
    else
    begin
      mem_rd_ff <= 1'b0;
      if (fetching && !pend_ff)
      begin
        mem_rd_ff   <= 1'b1;
        mem_addr_ff <= nxt_addr;
        pend_ff     <= 1'b1;
      end
      else if (got)
        pend_ff <= 1'b0;
    end
  end

  //--------------------------------------------------
  // sequencer
  //--------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff  <= cad_pkg::ST_FETCH;
      prefix_ff <= cad_pkg::PFX_NONE;
      mode_ff   <= cad_pkg::M_INH;
      opcode_ff <= 8'h00;
      b1_ff     <= 8'h00;
      b2_ff     <= 8'h00;
      p1_ff     <= 8'h00;
      p2_ff     <= 8'h00;
      cnt_ff    <= 2'd0;
    end
    else
    begin
      unique case (state_ff)
        cad_pkg::ST_FETCH:
          if (got)
          begin
            // a second prebyte is taken as an opcode, not stacked
            if (pfx_f(mem_rdata) != cad_pkg::PFX_NONE && prefix_ff == cad_pkg::PFX_NONE)
              prefix_ff <= pfx_f(mem_rdata); // RQ18
            else
            begin
              opcode_ff <= mem_rdata;
              mode_ff   <= nxt_mode;
              cnt_ff    <= 2'd0;
              state_ff  <= (opnd_n(nxt_mode) != 2'd0) ? cad_pkg::ST_OPND : cad_pkg::ST_CALC;
            end
          end
        cad_pkg::ST_OPND:
          if (got)
          begin
            if (cnt_ff == 2'd0)
              b1_ff <= mem_rdata;
            else
              b2_ff <= mem_rdata;
            if (cnt_ff + 2'd1 == opnd_n(mode_ff))
            begin
              cnt_ff   <= 2'd0;
              state_ff <= (ptr_n(mode_ff) != 2'd0) ? cad_pkg::ST_PTR : cad_pkg::ST_CALC;
            end
            else
              cnt_ff <= cnt_ff + 2'd1;
          end
        cad_pkg::ST_PTR:
          if (got)
          begin
            if (cnt_ff == 2'd0)
              p1_ff <= mem_rdata;
            else
              p2_ff <= mem_rdata;
            if (cnt_ff + 2'd1 == ptr_n(mode_ff))
            begin
              cnt_ff   <= 2'd0;
              state_ff <= cad_pkg::ST_CALC;
            end
            else
              cnt_ff <= cnt_ff + 2'd1;
          end
        cad_pkg::ST_CALC:
          state_ff <= cad_pkg::ST_DONE;
        cad_pkg::ST_DONE:
          if (dec_ack)
          begin
            state_ff  <= cad_pkg::ST_FETCH;
            prefix_ff <= cad_pkg::PFX_NONE;
          end
        default:
          state_ff <= cad_pkg::ST_FETCH;
      endcase
    end
  end

  //--------------------------------------------------
  // program counter
  //--------------------------------------------------
  // pc already points past the whole instruction when a branch is taken
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pc_ff <= RESET_PC;
    else if (got && (state_ff == cad_pkg::ST_FETCH || state_ff == cad_pkg::ST_OPND))
      pc_ff <= pc_ff + 16'h0001;
    else if (state_ff == cad_pkg::ST_DONE && dec_ack && branch_take
             && (dec_ff.mode == cad_pkg::M_REL_D || dec_ff.mode == cad_pkg::M_REL_I
                 || dec_ff.mode == cad_pkg::M_BITREL_D || dec_ff.mode == cad_pkg::M_BITREL_I))
      pc_ff <= dec_ff.rel_target; // RQ15 RQ23
  end

  //--------------------------------------------------
  // effective address
  //--------------------------------------------------
  always_comb
  begin
    logic use_y;
    logic [7:0] ix;
    use_y = (prefix_ff == cad_pkg::PFX_TO_Y) || (prefix_ff == cad_pkg::PFX_IND_Y);
    ix    = use_y ? y_val : x_val;
    unique case (mode_ff)
      cad_pkg::M_DIR_S, cad_pkg::M_BIT_D, cad_pkg::M_BITREL_D: nxt_ea = {8'h00, b1_ff}; // RQ3
      cad_pkg::M_DIR_L:    nxt_ea = {b1_ff, b2_ff}; // RQ4
      cad_pkg::M_IDX0:     nxt_ea = {8'h00, ix}; // RQ6
      cad_pkg::M_IDX_S:    nxt_ea = {8'h00, b1_ff} + {8'h00, ix}; // RQ5 RQ7 RQ24
      cad_pkg::M_IDX_L:    nxt_ea = {b1_ff, b2_ff} + {8'h00, ix}; // RQ5 RQ8 RQ24
      cad_pkg::M_IND_S, cad_pkg::M_BIT_I, cad_pkg::M_BITREL_I: nxt_ea = {8'h00, p1_ff}; // RQ9
      cad_pkg::M_IND_L:    nxt_ea = {p1_ff, p2_ff}; // RQ10
      cad_pkg::M_INDIDX_S: nxt_ea = {8'h00, p1_ff} + {8'h00, ix}; // RQ11 RQ12
      cad_pkg::M_INDIDX_L: nxt_ea = {p1_ff, p2_ff} + {8'h00, ix}; // RQ11
      default:             nxt_ea = 16'h0000;
    endcase
    unique case (mode_ff)
      cad_pkg::M_REL_I:                        rel_off = p1_ff; // RQ16
      cad_pkg::M_BITREL_D, cad_pkg::M_BITREL_I: rel_off = b2_ff;
      default:                                 rel_off = b1_ff; // RQ16
    endcase
    // prebyte combinations with no meaning are flagged, not executed
    unique case (prefix_ff)
      cad_pkg::PFX_TO_Y: nxt_illegal = !(mode_ff inside {cad_pkg::M_INH, cad_pkg::M_IMM,
        cad_pkg::M_DIR_S, cad_pkg::M_DIR_L, cad_pkg::M_IDX0, cad_pkg::M_IDX_S,
        cad_pkg::M_IDX_L}); // RQ19
      cad_pkg::PFX_INDIRECT: nxt_illegal = mode_ff inside {cad_pkg::M_INH, cad_pkg::M_IMM,
        cad_pkg::M_IDX0}; // RQ20
      cad_pkg::PFX_IND_Y: nxt_illegal = !(mode_ff inside {cad_pkg::M_INDIDX_S,
        cad_pkg::M_INDIDX_L}); // RQ21
      default: nxt_illegal = 1'b0;
    endcase
  end

  //--------------------------------------------------
  // decoded result
  //--------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dec_valid_ff <= 1'b0;
      dec_ff       <= '0;
    end
    else if (state_ff == cad_pkg::ST_CALC)
    begin
      dec_valid_ff       <= 1'b1;
      dec_ff.opcode      <= opcode_ff;
      dec_ff.prefix      <= prefix_ff;
      dec_ff.mode        <= mode_ff;
      dec_ff.use_y       <= (prefix_ff == cad_pkg::PFX_TO_Y) || (prefix_ff == cad_pkg::PFX_IND_Y);
      dec_ff.illegal     <= nxt_illegal;
      dec_ff.len         <= 3'd1 + {2'd0, prefix_ff != cad_pkg::PFX_NONE}
                            + {1'b0, opnd_n(mode_ff)}; // RQ17
      dec_ff.operand     <= b1_ff; // RQ2
      dec_ff.ea          <= nxt_ea;
      dec_ff.rel_target  <= pc_ff + {{8{rel_off[7]}}, rel_off}; // RQ15 RQ23
      dec_ff.is_trap     <= mode_ff == cad_pkg::M_INH && opcode_ff == `CAD_OP_TRAP; // RQ22
      dec_ff.is_wait     <= mode_ff == cad_pkg::M_INH && opcode_ff == `CAD_OP_WAIT; // RQ22
      dec_ff.is_halt     <= mode_ff == cad_pkg::M_INH && opcode_ff == `CAD_OP_HALT; // RQ22
    end
    else if (state_ff == cad_pkg::ST_DONE && dec_ack)
      dec_valid_ff <= 1'b0;
  end

  assign mem_rd    = mem_rd_ff;
  assign mem_addr  = mem_addr_ff;
  assign dec_valid = dec_valid_ff;
  assign dec       = dec_ff;
  assign pc        = pc_ff;

  //--------------------------------------------------
  // assertions
  //--------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_INH_LEN: assert property ($rose(dec_valid_ff) && dec_ff.mode == cad_pkg::M_INH // RQ1
    |-> dec_ff.len == 3'd1 + {2'd0, dec_ff.prefix != cad_pkg::PFX_NONE})
    else $error("inherent length wrong");
  AST_IMM_OPERAND: assert property ($rose(dec_valid_ff) && dec_ff.mode == cad_pkg::M_IMM // RQ2
    |-> dec_ff.operand == $past(b1_ff) && dec_ff.len >= 3'd2)
    else $error("immediate operand wrong");
  AST_DIR_SHORT: assert property ($rose(dec_valid_ff) && dec_ff.mode == cad_pkg::M_DIR_S // RQ3
    |-> dec_ff.ea <= `CAD_PAGE0_MAX)
    else $error("short direct outside page zero");
  AST_DIR_LONG: assert property ($rose(dec_valid_ff) && dec_ff.mode == cad_pkg::M_DIR_L // RQ4
    |-> dec_ff.ea == {b1_ff, b2_ff})
    else $error("long direct address wrong");
  AST_IDX_SHORT: assert property ($rose(dec_valid_ff) && dec_ff.mode == cad_pkg::M_IDX_S // RQ7
    |-> dec_ff.ea <= `CAD_IDX_SHORT_MAX && dec_ff.ea == {8'h00, b1_ff} + {8'h00, $past(idx)})
    else $error("short indexed address wrong");
  AST_INDIDX_S: assert property ($rose(dec_valid_ff) && dec_ff.mode == cad_pkg::M_INDIDX_S // RQ12
    |-> dec_ff.ea <= `CAD_IDX_SHORT_MAX)
    else $error("short indirect indexed out of range");
  AST_PTR_PAGE0: assert property (mem_rd_ff && state_ff == cad_pkg::ST_PTR // RQ9
    |-> mem_addr_ff <= `CAD_PAGE0_MAX)
    else $error("pointer read left page zero");
  AST_REL_PC: assert property (state_ff == cad_pkg::ST_DONE && dec_ack && branch_take // RQ23
    && dec_ff.mode == cad_pkg::M_REL_D |=> pc_ff == $past(dec_ff.rel_target))
    else $error("relative jump target not loaded");
  AST_LEN_RANGE: assert property ($rose(dec_valid_ff) // RQ17
    |-> dec_ff.len >= 3'd1 && dec_ff.len <= 3'd4)
    else $error("instruction length out of range");
  AST_Y_SEL: assert property ($rose(dec_valid_ff) && dec_ff.prefix == cad_pkg::PFX_TO_Y // RQ19
    |-> dec_ff.use_y)
    else $error("y prebyte did not select y");
  AST_ACK_DROP: assert property (state_ff == cad_pkg::ST_DONE && dec_ack // RQ18
    |=> !dec_valid_ff && state_ff == cad_pkg::ST_FETCH ##[1:8] mem_rd_ff)
    else $error("next fetch not started");

  COV_PREFIX_IND: cover property ($rose(dec_valid_ff) && dec_ff.mode == cad_pkg::M_IND_L);
  COV_Y_INDIDX: cover property ($rose(dec_valid_ff) && dec_ff.prefix == cad_pkg::PFX_IND_Y);
  COV_BRANCH: cover property (state_ff == cad_pkg::ST_DONE && dec_ack && branch_take);
  COV_LEN4: cover property ($rose(dec_valid_ff) && dec_ff.len == 3'd4);

endmodule

// file: cad_mem_model.sv
`timescale 1ns/100ps

module cad_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // core memory bus
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output logic      [7:0]  mem_rdata,
  output logic             mem_rvalid,
  // test control
  input  wire logic        slow,
  output logic             proto_err
);
  logic [7:0]  mem [0:65535];
  logic [1:0]  cnt_ff;
  logic [15:0] addr_ff;

  // unwritten bytes hold a pattern, never a stale copy of the program
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  // idle data toggles every cycle so a late sample never sees the last byte
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_ff     <= 2'h0;
      addr_ff    <= 16'h0000;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 8'h00;
      proto_err  <= 1'b0;
    end
    else
    begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      if (mem_rd)
      begin
        proto_err <= proto_err | (cnt_ff != 2'h0);
        cnt_ff    <= slow ? 2'h3 : 2'h1;
        addr_ff   <= mem_addr;
      end
      else if (cnt_ff == 2'h1)
      begin
        mem_rvalid <= 1'b1;
        mem_rdata  <= mem[addr_ff];
        cnt_ff     <= 2'h0;
      end
      else if (cnt_ff != 2'h0)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end
endmodule

// file: cad_pkg.sv
package cad_pkg;

  typedef enum logic [1:0] {
    PFX_NONE     = 2'b00,
    PFX_TO_Y     = 2'b01,
    PFX_INDIRECT = 2'b10,
    PFX_IND_Y    = 2'b11
  } cad_pfx_t;

  typedef enum logic [4:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX0, M_IDX_S, M_IDX_L,
    M_IND_S, M_IND_L, M_INDIDX_S, M_INDIDX_L, M_REL_D, M_REL_I,
    M_BIT_D, M_BIT_I, M_BITREL_D, M_BITREL_I
  } cad_mode_t;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_OPND  = 3'b001,
    ST_PTR   = 3'b011,
    ST_CALC  = 3'b010,
    ST_DONE  = 3'b110
  } cad_state_t;

  typedef struct packed {
    logic [7:0]  opcode;
    cad_pfx_t    prefix;
    cad_mode_t   mode;
    logic        use_y;
    logic        illegal;
    logic [2:0]  len;
    logic [7:0]  operand;
    logic [15:0] ea;
    logic [15:0] rel_target;
    logic        is_trap;
    logic        is_wait;
    logic        is_halt;
  } cad_dec_t;

endpackage

// file: test_cpu_addressing_mode_decoder.sv
`timescale 1ns/100ps
`include "cad_cfg.svh"

module test_cpu_addressing_mode_decoder;
  typedef struct {
    cad_pkg::cad_dec_t d;
    logic [7:0]        x;
    logic [7:0]        y;
    logic              take;
    logic              ck_ea;
    logic              ck_op;
    logic              ck_rel;
    logic [15:0]       pc_end;
    logic [15:0]       pc_next;
  } cad_exp_t;

  logic              clk;
  logic              reset;
  logic              mem_rd;
  logic [15:0]       mem_addr;
  logic [7:0]        mem_rdata;
  logic              mem_rvalid;
  logic [7:0]        x_val;
  logic [7:0]        y_val;
  logic              dec_ack;
  logic              branch_take;
  logic              dec_valid;
  cad_pkg::cad_dec_t dec;
  logic [15:0]       pc;
  logic              slow;
  logic              proto_err;
  integer            seed = 89553;
  int                err_count;
  int                total_checks;
  int                cyc;
  logic [15:0]       loc;
  logic [7:0]        ptr;
  cad_exp_t          exp_q[$];
  cad_exp_t          e;
  cad_pkg::cad_dec_t snap;

  logic [7:0] t_pre [28] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h00, 8'h90, 8'h00, 8'h00,
    8'h00, 8'h90, 8'h00, 8'h90, 8'h00, 8'h90, 8'h92, 8'h92, 8'h92, 8'h91, 8'h92, 8'h91,
    8'h00, 8'h92, 8'h00, 8'h92, 8'h00, 8'h92, 8'h91};
  logic [7:0] t_op [28] = '{8'h83, 8'h8F, 8'h8E, 8'h9D, 8'h5C, 8'hA6, 8'hA6, 8'hB6, 8'hC6,
    8'hF6, 8'hF6, 8'hE6, 8'hE6, 8'hD6, 8'hD6, 8'hB6, 8'hC6, 8'hE6, 8'hE6, 8'hD6, 8'hD6,
    8'h27, 8'h27, 8'h10, 8'h10, 8'h00, 8'h00, 8'hA6};
  cad_pkg::cad_mode_t t_md [28] = '{cad_pkg::M_INH, cad_pkg::M_INH, cad_pkg::M_INH,
    cad_pkg::M_INH, cad_pkg::M_INH, cad_pkg::M_IMM, cad_pkg::M_IMM, cad_pkg::M_DIR_S,
    cad_pkg::M_DIR_L, cad_pkg::M_IDX0, cad_pkg::M_IDX0, cad_pkg::M_IDX_S, cad_pkg::M_IDX_S,
    cad_pkg::M_IDX_L, cad_pkg::M_IDX_L, cad_pkg::M_IND_S, cad_pkg::M_IND_L,
    cad_pkg::M_INDIDX_S, cad_pkg::M_INDIDX_S, cad_pkg::M_INDIDX_L, cad_pkg::M_INDIDX_L,
    cad_pkg::M_REL_D, cad_pkg::M_REL_I, cad_pkg::M_BIT_D, cad_pkg::M_BIT_I,
    cad_pkg::M_BITREL_D, cad_pkg::M_BITREL_I, cad_pkg::M_IMM};

  cad_decoder #(.RESET_PC(16'h0000)) dut_u (.clk(clk), .reset(reset), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .x_val(x_val),
    .y_val(y_val), .dec_ack(dec_ack), .branch_take(branch_take), .dec_valid(dec_valid),
    .dec(dec), .pc(pc));
  cad_mem_model mem_u (.clk(clk), .reset(reset), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .slow(slow), .proto_err(proto_err));

  always #10 clk = ~clk;

  task automatic stop_test();
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic put(input logic [7:0] b);
    mem_u.mem[loc] = b;
    loc = loc + 16'h0001;
  endtask

  // ----------------------------------------------------------------
  // program builder: lays out one instruction and notes its decode
  // ----------------------------------------------------------------
  // taken jumps always go forward, so no byte is reused before it runs;
  // the first two jumps carry the program out of page zero, where pointers live
  task automatic add_ins(input logic [7:0] pre, input logic [7:0] op,
                         input cad_pkg::cad_mode_t md);
    cad_exp_t    x;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  off;
    logic [15:0] idx;
    logic [15:0] st;
    logic        rel;
    x = '{default: '0};
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    off = b2;
    x.x = 8'($random(seed));
    x.y = 8'($random(seed));
    rel = md inside {cad_pkg::M_REL_D, cad_pkg::M_REL_I, cad_pkg::M_BITREL_D,
                     cad_pkg::M_BITREL_I};
    x.take = (loc < 16'h0100) ? 1'b1 : 1'($random(seed));
    if (rel && x.take)
      off = (loc < 16'h0100) ? 8'h7E : {3'b000, b2[4:0]} + 8'h08;
    x.d.opcode = op;
    x.d.mode = md;
    x.d.use_y = (pre == 8'h90) || (pre == 8'h91);
    x.d.prefix = (pre == 8'h90) ? cad_pkg::PFX_TO_Y : (pre == 8'h91) ? cad_pkg::PFX_IND_Y :
                 (pre == 8'h92) ? cad_pkg::PFX_INDIRECT : cad_pkg::PFX_NONE;
    x.d.is_trap = (pre == 8'h00) && (op == `CAD_OP_TRAP);
    x.d.is_wait = (pre == 8'h00) && (op == `CAD_OP_WAIT);
    x.d.is_halt = (pre == 8'h00) && (op == `CAD_OP_HALT);
    x.d.illegal = (pre == 8'h91)
                  && !(md inside {cad_pkg::M_INDIDX_S, cad_pkg::M_INDIDX_L});
    idx = {8'h00, x.d.use_y ? x.y : x.x};
    x.ck_ea = !(md inside {cad_pkg::M_INH, cad_pkg::M_IMM, cad_pkg::M_REL_D, cad_pkg::M_REL_I});
    st = loc;
    if (pre != 8'h00)
      put(pre);
    put(op);
    case (md)
      cad_pkg::M_INH: ;
      cad_pkg::M_IMM:
      begin
        put(b1);
        x.d.operand = b1;
        x.ck_op = 1'b1;
      end
      cad_pkg::M_DIR_S, cad_pkg::M_BIT_D:
      begin
        put(b1);
        x.d.ea = {8'h00, b1};
      end
      cad_pkg::M_DIR_L, cad_pkg::M_IDX_L:
      begin
        put(b1);
        put(b2);
        x.d.ea = {b1, b2} + ((md == cad_pkg::M_IDX_L) ? idx : 16'h0000);
      end
      cad_pkg::M_IDX0: x.d.ea = idx;
      cad_pkg::M_IDX_S:
      begin
        put(b1);
        x.d.ea = {8'h00, b1} + idx;
      end
      cad_pkg::M_REL_D: put(off);
      cad_pkg::M_BITREL_D:
      begin
        put(b1);
        put(off);
        x.d.ea = {8'h00, b1};
      end
      default:
      begin
        put(ptr);
        mem_u.mem[{8'h00, ptr}] = (md == cad_pkg::M_REL_I) ? off : b1;
        mem_u.mem[{8'h00, ptr + 8'h01}] = b2;
        ptr = ptr + 8'h02;
        if (md == cad_pkg::M_BITREL_I)
          put(off);
        x.d.ea = (md == cad_pkg::M_IND_L) ? {b1, b2} :
                 (md == cad_pkg::M_INDIDX_L) ? {b1, b2} + idx :
                 (md == cad_pkg::M_INDIDX_S) ? {8'h00, b1} + idx : {8'h00, b1};
      end
    endcase
    x.d.len = 3'(loc - st);
    x.d.rel_target = loc + {{8{off[7]}}, off};
    x.ck_rel = rel;
    x.pc_end = loc;
    x.pc_next = (rel && x.take) ? x.d.rel_target : loc;
    loc = x.pc_next;
    exp_q.push_back(x);
  endtask

  // ----------------------------------------------------------------
  // stimulus and watcher
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    dec_ack = 1'b0;
    branch_take = 1'b0;
    x_val = 8'h00;
    y_val = 8'h00;
    slow = 1'b0;
    loc = 16'h0000;
    ptr = 8'h10;
    #1;
    add_ins(8'h00, 8'h20, cad_pkg::M_REL_D);
    add_ins(8'h00, 8'h20, cad_pkg::M_REL_D);
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < 28; i++)
        add_ins(t_pre[i], t_op[i], t_md[i]);
    x_val = exp_q[0].x;
    y_val = exp_q[0].y;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    while (exp_q.size() != 0)
      @(posedge clk);
    repeat (6) @(posedge clk);
    check("mem_overlap", 64'(proto_err), 64'h0000_0000_0000_0000);
    stop_test();
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    slow <= 1'($random(seed));
    if (cyc == 8000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    forever
    begin
      @(posedge clk);
      if (dec_valid !== 1'b1)
        branch_take <= cyc[0];
      else if (exp_q.size() == 0)
        check("extra_decode", 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0000);
      else
      begin
        e = exp_q.pop_front();
        check("opcode", 64'(dec.opcode), 64'(e.d.opcode));
        check("prefix", 64'(dec.prefix), 64'(e.d.prefix));
        check("mode", 64'(dec.mode), 64'(e.d.mode));
        check("use_y", 64'(dec.use_y), 64'(e.d.use_y));
        check("illegal", 64'(dec.illegal), 64'(e.d.illegal));
        check("len", 64'(dec.len), 64'(e.d.len));
        check("flags", 64'({dec.is_trap, dec.is_wait, dec.is_halt}),
              64'({e.d.is_trap, e.d.is_wait, e.d.is_halt}));
        check("pc_at_decode", 64'(pc), 64'(e.pc_end));
        if (e.ck_op)
          check("operand", 64'(dec.operand), 64'(e.d.operand));
        if (e.ck_ea)
          check("ea", 64'(dec.ea), 64'(e.d.ea));
        if (e.ck_rel)
          check("rel_target", 64'(dec.rel_target), 64'(e.d.rel_target));
        snap = dec;
        repeat (cyc[1:0]) @(posedge clk);
        check("dec_hold", 64'(dec), 64'(snap));
        dec_ack <= 1'b1;
        branch_take <= e.take;
        @(posedge clk);
        dec_ack <= 1'b0;
        if (exp_q.size() != 0)
        begin
          x_val <= exp_q[0].x;
          y_val <= exp_q[0].y;
        end
        @(posedge clk);
        check("pc_after", 64'(pc), 64'(e.pc_next));
        check("valid_drop", 64'(dec_valid), 64'h0000_0000_0000_0000);
      end
    end
  end
endmodule
